// ### sssy_map.vh
`ifndef SSSY_MAP_VH
`define SSSY_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SSSY_OFS_BUF 8'h00
`define SSSY_OFS_CTL1 8'h04
`define SSSY_OFS_CTL3 8'h08
`define SSSY_OFS_STAT 8'h0C
`define SSSY_OFS_INT 8'h10

// ----------------------------------------
// Control, status and interrupt fields
// ----------------------------------------
`define SSSY_C1_WRITE_COLLISION_FLAG 7
`define SSSY_C1_OVF 6
`define SSSY_C1_EN 5
`define SSSY_C1_CKP 4
`define SSSY_C1_MODE 3:0
`define SSSY_C3_BOEN 4
`define SSSY_ST_SMP 7
`define SSSY_ST_CKE 6
`define SSSY_ST_BF 0
`define SSSY_ST_WMASK 8'hC0
`define SSSY_INT_EN 0
`define SSSY_INT_FLAG 1

// ----------------------------------------
// Port modes
// ----------------------------------------
`define SSSY_MODE_M4 4'h0
`define SSSY_MODE_M16 4'h1
`define SSSY_MODE_SLV_SS 4'h4
`define SSSY_MODE_SLV 4'h5

// ----------------------------------------
// Master half-bit divider limits and frame counter ends
// ----------------------------------------
`define SSSY_DIV4 6'h01
`define SSSY_DIV16 6'h07
`define SSSY_DIV64 6'h1F
`define SSSY_TGL_LAST 4'hF
`define SSSY_BIT_LAST 3'h7

// ----------------------------------------
// Reset values and bus answers
// ----------------------------------------
`define SSSY_RST_BYTE 8'h00
`define SSSY_PIN_RST 3'h2
`define SSSY_RESP_OK 2'h0
`define SSSY_RESP_ERR 2'h2

`endif

// ### sssy_port.v
// How it works
// - Select rising resets slave receive logic
// - Select-controlled slave only when mode is 0100
// - Select low enables shifting and drives output
// - Select high floats output after the pin synchroniser delay, mid-byte too
// - Select high or disable clears bit counter
// - Master sleep freezes transfer, resumes on wake
// - Slave shifts during sleep, byte flags, wakes
// - Full byte moves to buffer unless an unread byte is kept, sets flags
// - Shift most significant bit first
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "sssy_map.vh"

module sssy_port (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // AXI4-Lite write
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Serial pins
  input wire sck_in,
  output reg sck_out,
  output wire sck_oe_n,
  input wire sel_n_in,
  input wire sdi_in,
  output wire serial_data_out,
  output wire sdo_oe_n,
  // Core power state
  input wire core_sleep,
  output wire wake_req
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wire [2:0] pin_raw;
  wire [2:0] pin_rst;
  reg [2:0] s1_q;
  reg [2:0] s2_q;
  reg [2:0] s3_q;
  reg [2:0] flt_q;
  assign pin_raw = {sdi_in, sel_n_in, sck_in};
  assign pin_rst = `SSSY_PIN_RST;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      always @(posedge clk) begin
        if (!rstn) begin
          s1_q[gi] <= pin_rst[gi];
          s2_q[gi] <= pin_rst[gi];
          s3_q[gi] <= pin_rst[gi];
          flt_q[gi] <= pin_rst[gi];
        end else begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          // A change counts only once two stages agree
          if (s2_q[gi] == s3_q[gi]) begin
            flt_q[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  reg [7:0] ctl1_q;
  reg [7:0] ctl3_q;
  reg [1:0] stat_cfg_q;
  reg bf_q;
  reg int_en_q;
  reg int_flag_q;
  reg [7:0] buf_q;
  reg [7:0] rx_q;
  reg [7:0] tx_q;
  reg [2:0] cnt_q;
  reg sck_prev_q;
  reg mrun_q;
  reg [3:0] tgl_q;
  reg [5:0] div_q;
  reg [7:0] awa_q;
  reg aw_have_q;
  reg [7:0] wd_q;
  reg w_strb_q;
  reg w_have_q;

  wire port_en = ctl1_q[`SSSY_C1_EN];
  wire clock_idle_polarity = ctl1_q[`SSSY_C1_CKP];
  wire cke = stat_cfg_q[0];
  wire [3:0] mode = ctl1_q[`SSSY_C1_MODE];
  wire is_master = (mode[3:2] == 2'h0);
  wire is_slave = (mode == `SSSY_MODE_SLV_SS) || (mode == `SSSY_MODE_SLV);
  wire sel_ctl = (mode == `SSSY_MODE_SLV_SS);
  wire sel_act = ~flt_q[1];
  wire slave_go = port_en && is_slave && (!sel_ctl || sel_act);
  wire mod_rst = !port_en || (is_slave && sel_ctl && !sel_act);

  // ----------------------------------------
  // Master bit clock
  // ----------------------------------------
  reg [5:0] div_lim;
  always @* begin
    case (mode)
      `SSSY_MODE_M4: div_lim = `SSSY_DIV4;
      `SSSY_MODE_M16: div_lim = `SSSY_DIV16;
      default: div_lim = `SSSY_DIV64;
    endcase
  end

  // Sleep stops the divider, so the frame simply waits in place
  wire tick = mrun_q && !core_sleep && (div_q == div_lim);

  // ----------------------------------------
  // Edge classification
  // ----------------------------------------
  wire s_edge = slave_go && (flt_q[0] != sck_prev_q);
  wire m_edge = port_en && is_master && tick;
  wire any_edge = s_edge || m_edge;
  wire new_lvl = is_master ? ~sck_out : flt_q[0];
  wire new_act = new_lvl ^ clock_idle_polarity;
  // Clock edge set samples on the leading edge
  wire samp_ev = any_edge && (cke ? new_act : !new_act);
  wire shift_ev = any_edge && !(cke ? new_act : !new_act);
  wire [7:0] rx_full = {rx_q[6:0], flt_q[2]};
  wire byte_done = samp_ev && (cnt_q == `SSSY_BIT_LAST);
  wire busy = mrun_q || (cnt_q != 3'h0);

  assign serial_data_out = tx_q[7];
  assign sdo_oe_n = !(port_en && (is_master || slave_go));
  assign sck_oe_n = !(port_en && is_master);
  assign wake_req = core_sleep && int_flag_q && int_en_q;

  // ----------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  wire wr_do = wr_fire && w_strb_q;
  wire rd_fire = s_axi_arvalid && s_axi_arready;
  wire wr_buf = wr_do && (awa_q == `SSSY_OFS_BUF);
  wire wr_c1 = wr_do && (awa_q == `SSSY_OFS_CTL1);
  wire wr_c3 = wr_do && (awa_q == `SSSY_OFS_CTL3);
  wire wr_st = wr_do && (awa_q == `SSSY_OFS_STAT);
  wire wr_int = wr_do && (awa_q == `SSSY_OFS_INT);
  wire rd_buf = rd_fire && (s_axi_araddr == `SSSY_OFS_BUF);
  // Buffer writes mid-transfer or with a pending collision are dropped
  wire buf_ok = wr_buf && !busy && !ctl1_q[`SSSY_C1_WRITE_COLLISION_FLAG];
  wire wr_map = (awa_q == `SSSY_OFS_BUF) || (awa_q == `SSSY_OFS_CTL1) ||
    (awa_q == `SSSY_OFS_CTL3) || (awa_q == `SSSY_OFS_STAT) || (awa_q == `SSSY_OFS_INT);

  reg [7:0] rd_byte;
  reg rd_map;
  always @* begin
    rd_map = 1'b1;
    case (s_axi_araddr)
      `SSSY_OFS_BUF: rd_byte = buf_q;
      `SSSY_OFS_CTL1: rd_byte = ctl1_q;
      `SSSY_OFS_CTL3: rd_byte = ctl3_q;
      `SSSY_OFS_STAT: rd_byte = {stat_cfg_q[1], stat_cfg_q[0], 5'h00, bf_q};
      `SSSY_OFS_INT: rd_byte = {6'h00, int_flag_q, int_en_q};
      default: begin
        rd_byte = `SSSY_RST_BYTE;
        rd_map = 1'b0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rstn) begin
      aw_have_q <= 1'b0;
      awa_q <= 8'h00;
      w_have_q <= 1'b0;
      wd_q <= 8'h00;
      w_strb_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SSSY_RESP_OK;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `SSSY_RESP_OK;
      s_axi_rdata <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wd_q <= s_axi_wdata[7:0];
        w_strb_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? `SSSY_RESP_OK : `SSSY_RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_map ? `SSSY_RESP_OK : `SSSY_RESP_ERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Port core
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      ctl1_q <= `SSSY_RST_BYTE;
      ctl3_q <= `SSSY_RST_BYTE;
      stat_cfg_q <= 2'h0;
      bf_q <= 1'b0;
      int_en_q <= 1'b0;
      int_flag_q <= 1'b0;
      buf_q <= `SSSY_RST_BYTE;
      rx_q <= `SSSY_RST_BYTE;
      tx_q <= `SSSY_RST_BYTE;
      cnt_q <= 3'h0;
      sck_prev_q <= 1'b0;
      sck_out <= 1'b0;
      mrun_q <= 1'b0;
      tgl_q <= 4'h0;
      div_q <= 6'h00;
    end else begin
      sck_prev_q <= flt_q[0];
      if (wr_c1) begin
        ctl1_q <= wd_q;
      end
      if (wr_c3) begin
        ctl3_q <= wd_q;
      end
      if (wr_st) begin
        stat_cfg_q <= wd_q[`SSSY_ST_SMP:`SSSY_ST_CKE];
      end
      if (wr_int) begin
        int_en_q <= wd_q[`SSSY_INT_EN];
        if (wd_q[`SSSY_INT_FLAG]) begin
          int_flag_q <= 1'b0;
        end
      end
      if (rd_buf) begin
        bf_q <= 1'b0;
      end
      if (wr_buf && !buf_ok) begin
        ctl1_q[`SSSY_C1_WRITE_COLLISION_FLAG] <= 1'b1;
      end
      if (!mrun_q || !is_master) begin
        sck_out <= clock_idle_polarity;
      end
      if (mrun_q && !core_sleep) begin
        div_q <= tick ? 6'h00 : div_q + 6'h01;
      end
      if (m_edge) begin
        sck_out <= ~sck_out;
        tgl_q <= tgl_q + 4'h1;
        if (tgl_q == `SSSY_TGL_LAST) begin
          mrun_q <= 1'b0;
        end
      end
      if (buf_ok) begin
        tx_q <= wd_q;
        mrun_q <= is_master && port_en;
        tgl_q <= 4'h0;
        div_q <= 6'h00;
      end
      // A shift edge while the bit count is zero leaves the top bit in place
      if (shift_ev && cnt_q != 3'h0) begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
      if (samp_ev) begin
        rx_q <= rx_full;
        cnt_q <= cnt_q + 3'h1;
      end
      if (byte_done) begin
        int_flag_q <= 1'b1;
        // Unread byte with overwrite disabled is kept, not replaced
        if (bf_q && !ctl3_q[`SSSY_C3_BOEN]) begin
          ctl1_q[`SSSY_C1_OVF] <= 1'b1;
        end else begin
          buf_q <= rx_full;
          bf_q <= 1'b1;
        end
      end
      if (mod_rst) begin
        cnt_q <= 3'h0;
        mrun_q <= 1'b0;
        tgl_q <= 4'h0;
      end
    end
  end

endmodule
`default_nettype wire

// ### sssy_port_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "sssy_map.vh"
module sssy_port_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  // Pins and power
  input wire logic sel_n_in,
  input wire logic sdo_oe_n,
  input wire logic sck_out,
  input wire logic core_sleep,
  input wire logic wake_req
);
  // ----------------------------------------
  // Shadow of enable, polarity and mode
  // ----------------------------------------
  logic [5:0] cfg_q;
  wire logic aw_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire logic slv_ss = cfg_q == 6'h24;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_q <= 6'h00;
    end else if (aw_w && s_axi_awaddr == `SSSY_OFS_CTL1) begin
      cfg_q <= s_axi_wdata[5:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_desel_float: assert property ((slv_ss && sel_n_in) [*6] |-> sdo_oe_n)
    else $error("data out driven while deselected");
  chk_sel_drive: assert property ((slv_ss && !sel_n_in) [*6] |-> !sdo_oe_n)
    else $error("data out floating while selected");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_wr_answer: assert property (aw_w |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  chk_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  chk_rd_pad: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  chk_wake_sleep: assert property (wake_req |-> core_sleep)
    else $error("wake request while awake");
  chk_sleep_freeze: assert property (core_sleep [*2] |-> $stable(sck_out))
    else $error("serial clock moved in sleep");
  cover property (slv_ss && $fell(sel_n_in));
  cover property ($rose(wake_req));
  cover property (s_axi_rvalid && s_axi_arvalid);
endmodule
`default_nettype wire

// ### sssy_spi_master.sv
`timescale 1ns/100ps
`default_nettype none
module sssy_spi_master (
  // Serial lines
  output logic sck,
  output logic sel_n,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n
);
  initial begin
    sck = 1'b0;
    sel_n = 1'b1;
    mosi = 1'b1;
  end
  // ----------------------------------------
  // One frame; fewer than 8 bits aborts it
  // ----------------------------------------
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    #3 sel_n = 1'b0;
    #160;
    for (int i = 0; i < nbits; i++) begin
      mosi = tx[7 - i];
      #80 sck = 1'b1;
      // Late sample leaves room for the slave's pin synchroniser
      #79 rx = {rx[6:0], miso_oe_n ? 1'bx : miso};
      #1 sck = 1'b0;
    end
    #80 sel_n = 1'b1;
    mosi = ~mosi;
  endtask
endmodule
`default_nettype wire

// ### sssy_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "sssy_map.vh"
module sssy_port_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic core_sleep = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  wire logic awready, wready, bvalid, arready, rvalid, sck, sel_n, mosi, miso, miso_oe_n, wake;
  wire logic msck, msck_oe_n;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  logic [31:0] d;
  logic [1:0] r;
  logic [7:0] rx;
  int n_errors = 0;
  int comparisons = 0;
  sssy_port u_sssy_port (.clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .sck_in(sck), .sck_out(msck),
    .sck_oe_n(msck_oe_n), .sel_n_in(sel_n), .sdi_in(mosi), .serial_data_out(miso), .sdo_oe_n(miso_oe_n),
    .core_sleep(core_sleep), .wake_req(wake));
  sssy_spi_master u_sssy_spi_master (.sck(sck), .sel_n(sel_n), .mosi(mosi), .miso(miso),
    .miso_oe_n(miso_oe_n));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic da, dw;
    da = 1'b0;
    dw = 1'b0;
    // Start on a rising edge, or ready is judged a cycle late
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(da && dw)) begin
      @(negedge clk);
      da = da | awready;
      dw = dw | wready;
      @(posedge clk);
      awvalid <= !da;
      wvalid <= !dw;
    end
    @(negedge clk);
    while (!bvalid) @(negedge clk);
    r = bresp;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    @(negedge clk);
    while (!arready) @(negedge clk);
    @(posedge clk);
    arvalid <= 1'b0;
    @(negedge clk);
    while (!rvalid) @(negedge clk);
    d = rdata;
    r = rresp;
    @(posedge clk);
  endtask
  task automatic finish_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic t_regs;
    rd(`SSSY_OFS_CTL1);
    chk("ctl1 reset", d, 32'h0);
    rd(8'h20);
    chk("unmapped resp", r, `SSSY_RESP_ERR);
    $display("test regs done");
  endtask
  task automatic t_slave;
    wr(`SSSY_OFS_STAT, 32'h40);
    wr(`SSSY_OFS_CTL1, 32'h24);
    chk("write resp", r, `SSSY_RESP_OK);
    wr(`SSSY_OFS_INT, 32'h01);
    wr(`SSSY_OFS_BUF, 32'hA5);
    u_sssy_spi_master.xfer(8'h3C, 8, rx);
    chk("sent byte", rx, 8'hA5);
    repeat (6) @(posedge clk);
    rd(`SSSY_OFS_STAT);
    chk("buffer full", d[0], 1'b1);
    rd(`SSSY_OFS_INT);
    chk("int flag", d[1], 1'b1);
    rd(`SSSY_OFS_BUF);
    chk("rx byte", d, 32'h3C);
    rd(`SSSY_OFS_STAT);
    chk("full cleared", d[0], 1'b0);
    $display("test slave done");
  endtask
  task automatic t_abort;
    wr(`SSSY_OFS_BUF, 32'hC3);
    u_sssy_spi_master.xfer(8'hFF, 3, rx);
    repeat (6) @(negedge clk);
    chk("float", miso_oe_n, 1'b1);
    wr(`SSSY_OFS_BUF, 32'h5A);
    u_sssy_spi_master.xfer(8'h81, 8, rx);
    chk("realigned tx", rx, 8'h5A);
    repeat (6) @(posedge clk);
    rd(`SSSY_OFS_BUF);
    chk("realigned rx", d, 32'h81);
    wr(`SSSY_OFS_CTL1, 32'h25);
    repeat (6) @(negedge clk);
    chk("no select mode", miso_oe_n, 1'b0);
    wr(`SSSY_OFS_CTL1, 32'h24);
    $display("test abort done");
  endtask
  task automatic t_sleep;
    core_sleep <= 1'b1;
    wr(`SSSY_OFS_INT, 32'h03);
    u_sssy_spi_master.xfer(8'h66, 8, rx);
    repeat (6) @(negedge clk);
    chk("wake", wake, 1'b1);
    wr(`SSSY_OFS_INT, 32'h02);
    u_sssy_spi_master.xfer(8'h99, 8, rx);
    repeat (6) @(negedge clk);
    chk("no wake", wake, 1'b0);
    rd(`SSSY_OFS_INT);
    chk("flag in sleep", d[1], 1'b1);
    rd(`SSSY_OFS_CTL1);
    chk("overflow set", d, 32'h64);
    rd(`SSSY_OFS_BUF);
    chk("older byte kept", d, 32'h66);
    core_sleep <= 1'b0;
    $display("test sleep done");
  endtask
  task automatic t_master;
    int tg;
    int ts;
    logic pv;
    logic sl;
    tg = 0;
    ts = 0;
    sl = 1'b0;
    wr(`SSSY_OFS_CTL1, 32'h20);
    wr(`SSSY_OFS_BUF, 32'h96);
    @(negedge clk);
    pv = msck;
    // Sleep lands mid-frame; a toggle counts against the level before its edge
    for (int i = 0; i < 90; i++) begin
      @(posedge clk);
      core_sleep <= (i >= 10 && i < 40);
      @(negedge clk);
      if (msck !== pv) begin
        tg++;
        if (sl) begin
          ts++;
        end
      end
      pv = msck;
      sl = core_sleep;
    end
    chk("master toggles", tg, 32'h10);
    chk("frozen in sleep", ts, 32'h0);
    chk("clock drive", msck_oe_n, 1'b0);
    chk("clock idle", msck, 1'b0);
    rd(`SSSY_OFS_BUF);
    chk("master rx", d, 32'h0);
    $display("test master done");
  endtask
  initial begin
    #200000;
    n_errors++;
    finish_test;
  end
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs;
    t_slave;
    t_abort;
    t_sleep;
    t_master;
    finish_test;
  end
endmodule
bind sssy_port sssy_port_monitor u_sssy_port_monitor (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .sel_n_in, .sdo_oe_n, .sck_out, .core_sleep, .wake_req);
`default_nettype wire
